// *** bench/smms_regs_asserts.sv ***
// Port-level checker for the register bank
module smms_regs_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mask_rom_variant,
    input wire logic        conversion_start_bit,
    input wire logic        converter_mode_bit,
    input wire logic        dsadc_conv_start,
    input wire logic [7:0]  module_run,
    input wire logic        serial_unit_a_ch1_reset,
    input wire logic        serial_unit_a_ch2_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup_access;
        psel && !penable ##1 psel && penable;
    endsequence
    property p_ready_lat;
        s_setup_access |=> pready;
    endproperty
    property p_ready_once;
        pready |=> !pready;
    endproperty
    property p_ready_cause;
        pready |-> psel && penable && $past(penable);
    endproperty
    property p_err_hole;
        pready && paddr == 32'h0003ffc8 |-> pslverr && prdata == 32'h0;
    endproperty
    property p_mask_rd;
        pready && !pwrite && mask_rom_variant && paddr == 32'h0003ffe8 |-> !prdata[7];
    endproperty
    property p_ch_reset;
        serial_unit_a_ch1_reset == !module_run[6] && serial_unit_a_ch2_reset == !module_run[5];
    endproperty
    property p_start_cause;
        dsadc_conv_start |-> $past(conversion_start_bit && !converter_mode_bit && module_run[3]);
    endproperty
    property p_start_pulse;
        dsadc_conv_start |=> !dsadc_conv_start;
    endproperty
    property p_run_hold;
        $changed(module_run[6:0]) |-> $past(pready && pwrite);
    endproperty
    a_ready_lat: assert property (p_ready_lat) else $error("pready late");
    a_ready_once: assert property (p_ready_once) else $error("pready too long");
    a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
    a_err_hole: assert property (p_err_hole) else $error("hole not refused");
    a_mask_rd: assert property (p_mask_rd) else $error("masked bit visible");
    a_ch_reset: assert property (p_ch_reset) else $error("channel reset wrong");
    a_start_cause: assert property (p_start_cause) else $error("bad start");
    a_start_pulse: assert property (p_start_pulse) else $error("start too long");
    a_run_hold: assert property (p_run_hold) else $error("stop bits moved");
endmodule : smms_regs_asserts

// *** bench/tb_smms_regs.sv ***
// Self-checking bench for the register bank
`include "smms_cfg.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_smms_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, mask_rom_variant, e, irq;
    logic        dsadc_conv_done, conversion_start_bit, converter_mode_bit, pready, pslverr;
    logic        dsadc_irq_request, dsadc_conv_start, software_standby_select;
    logic        low_speed_select, direct_transfer_select, medium_speed_select;
    logic        serial_unit_a_ch1_reset, serial_unit_a_ch2_reset;
    logic [7:0]  module_run;
    logic [31:0] paddr, pwdata, prdata, r;
    int          n_fail = 0, n_checks = 0, n_starts = 0;
    smms_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
        .prdata, .pready, .pslverr, .mask_rom_variant, .dsadc_conv_done, .conversion_start_bit,
        .converter_mode_bit, .dsadc_irq_request, .dsadc_conv_start, .software_standby_select,
        .low_speed_select, .direct_transfer_select, .medium_speed_select, .module_run,
        .serial_unit_a_ch1_reset, .serial_unit_a_ch2_reset, .irq);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Outputs are read mid-cycle so edge updates have landed
    always @(negedge pclk) n_starts += int'(dsadc_conv_start === 1'b1);
    task automatic test_done;
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    task automatic tick(input int n);
        repeat (n) @(negedge pclk);
    endtask : tick
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {14'h0, a, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Answer and data are taken at the very edge that samples pready high
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] ex);
        xfer(1'b0, a, 8'h0);
        `CHK("prdata", {24'h0, ex}, {r[31:8], r[7:0] & m})
        `CHK("pslverr", 1'b0, e)
    endtask : rd
    // Sel 0 pulses conversion completion, otherwise the start input, for one cycle
    task automatic pin(input int sel);
        @(posedge pclk);
        if (sel == 0) begin
            dsadc_conv_done <= 1'b1;
        end else begin
            conversion_start_bit <= 1'b1;
        end
        @(posedge pclk);
        dsadc_conv_done <= 1'b0;
        conversion_start_bit <= 1'b0;
    endtask : pin
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, mask_rom_variant} = '0;
        {dsadc_conv_done, conversion_start_bit, converter_mode_bit} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        `CHK("run", 8'h8a, module_run)
        `CHK("modes", 4'h0, {software_standby_select, low_speed_select,
            direct_transfer_select, medium_speed_select})
        rd(`SMMS_OFF_SYSCTL_ONE, 8'h88, 8'h00);
        rd(`SMMS_OFF_SYSCTL_TWO, 8'h0c, 8'h00);
        rd(`SMMS_OFF_IRQ_EN_TWO, 8'h20, 8'h20);
        rd(`SMMS_OFF_IRQ_REQ_TWO, 8'h20, 8'h00);
        rd(`SMMS_OFF_CLK_HALT_ONE, 8'hff, 8'h8a);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, `SMMS_OFF_SYSCTL_ONE, i ? 8'h80 : 8'h88);
            xfer(1'b1, `SMMS_OFF_SYSCTL_TWO, i ? 8'h04 : 8'h0c);
            tick(1);
            `CHK("modes", i ? 4'h9 : 4'hf, {software_standby_select, low_speed_select,
                direct_transfer_select, medium_speed_select})
        end
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, `SMMS_OFF_CLK_HALT_ONE, 8'h1 << i);
            tick(1);
            `CHK("run", 8'h1 << i, module_run)
            `CHK("chrst", {i != 6, i != 5}, {serial_unit_a_ch1_reset, serial_unit_a_ch2_reset})
            rd(`SMMS_OFF_CLK_HALT_ONE, 8'hff, 8'h1 << i);
        end
        @(posedge pclk) mask_rom_variant <= 1'b1;
        xfer(1'b1, `SMMS_OFF_CLK_HALT_ONE, 8'hff);
        rd(`SMMS_OFF_CLK_HALT_ONE, 8'hff, 8'h7f);
        xfer(1'b1, `SMMS_OFF_CLK_HALT_ONE, 8'h00);
        @(posedge pclk) mask_rom_variant <= 1'b0;
        rd(`SMMS_OFF_CLK_HALT_ONE, 8'hff, 8'h80);
        pin(0);
        tick(2);
        `CHK("irqreq", 1'b1, dsadc_irq_request)
        xfer(1'b1, `SMMS_OFF_IRQ_REQ_TWO, 8'hff);
        rd(`SMMS_OFF_IRQ_REQ_TWO, 8'h20, 8'h20);
        xfer(1'b1, `SMMS_OFF_IRQ_EN_TWO, 8'h00);
        tick(2);
        `CHK("irqreq", 1'b0, dsadc_irq_request)
        xfer(1'b1, `SMMS_OFF_IRQ_EN_TWO, 8'h20);
        xfer(1'b1, `SMMS_OFF_IRQ_REQ_TWO, 8'h00);
        rd(`SMMS_OFF_IRQ_REQ_TWO, 8'h20, 8'h00);
        tick(2);
        `CHK("irqreq", 1'b0, dsadc_irq_request)
        rd(`SMMS_OFF_EVT_STATUS, 8'h01, 8'h01);
        `CHK("irq", 1'b0, irq)
        xfer(1'b1, `SMMS_OFF_EVT_ENABLE, 8'h01);
        tick(2);
        `CHK("irq", 1'b1, irq)
        xfer(1'b1, `SMMS_OFF_EVT_CLEAR, 8'h01);
        tick(2);
        `CHK("irq", 1'b0, irq)
        rd(`SMMS_OFF_EVT_CLEAR, 8'hff, 8'h00);
        // Start must be refused when stopped or in the wrong mode
        pin(1);
        xfer(1'b1, `SMMS_OFF_CLK_HALT_ONE, 8'h08);
        @(posedge pclk) converter_mode_bit <= 1'b1;
        pin(1);
        @(posedge pclk) converter_mode_bit <= 1'b0;
        pin(1);
        tick(3);
        `CHK("starts", 1, n_starts)
        rd(`SMMS_OFF_EVT_STATUS, 8'h02, 8'h02);
        xfer(1'b0, 16'hfff2, 8'h00);
        `CHK("hole", 33'h100000000, {e, r})
        test_done();
    end
    initial begin
        #100us;
        n_fail++;
        test_done();
    end
endmodule : tb_smms_regs
bind smms_regs smms_regs_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .mask_rom_variant, .conversion_start_bit, .converter_mode_bit,
    .dsadc_conv_start, .module_run, .serial_unit_a_ch1_reset, .serial_unit_a_ch2_reset);

// *** logic/smms_cfg.svh ***
// Offsets, field positions and reset values of the system mode and module stop bank
`ifndef SMMS_CFG_SVH
`define SMMS_CFG_SVH

`define SMMS_OFF_SYSCTL_ONE      16'hfff0
`define SMMS_OFF_SYSCTL_TWO      16'hfff1
`define SMMS_OFF_IRQ_EN_TWO      16'hfff4
`define SMMS_OFF_IRQ_REQ_TWO     16'hfff7
`define SMMS_OFF_CLK_HALT_ONE    16'hfffa
`define SMMS_OFF_EVT_STATUS      16'hffe0
`define SMMS_OFF_EVT_CLEAR       16'hffe4
`define SMMS_OFF_EVT_ENABLE      16'hffe8

`define SMMS_BIT_DSADC_IRQ       5
`define SMMS_BIT_SW_STANDBY      7
`define SMMS_BIT_LOW_SPEED       3
`define SMMS_BIT_DIRECT_XFER     3
`define SMMS_BIT_MEDIUM_SPEED    2
`define SMMS_BIT_SERIAL_B        7
`define SMMS_BIT_SERIAL_A_CH1    6
`define SMMS_BIT_SERIAL_A_CH2    5

`define SMMS_RST_DSADC_IRQ_EN    1'h1
`define SMMS_RST_DSADC_IRQ_FLAG  1'h0
`define SMMS_RST_SW_STANDBY      1'h0
`define SMMS_RST_LOW_SPEED       1'h0
`define SMMS_RST_DIRECT_XFER     1'h0
`define SMMS_RST_MEDIUM_SPEED    1'h0
`define SMMS_RST_CLK_HALT_ONE    8'h8a
`define SMMS_RST_EVT_ENABLE      2'h0

`endif

// *** logic/smms_pkg.sv ***
// Types shared by the system mode and module stop bank
package smms_pkg;
    typedef enum logic [1:0] {
        SMMS_APB_IDLE,
        SMMS_APB_ACCESS
    } smms_apb_state_t;

    typedef logic [7:0] smms_byte_t;
endpackage : smms_pkg

// *** logic/smms_regs.sv ***
// APB register bank for low-power mode selection, converter interrupt and module stop
//
// The implementer's own choice: the APB interface to the registers.
`include "smms_cfg.svh"

// How it works
// - Converter interrupt enable at bit 5 of enable register, resets to 1.
// - Converter completion sets the request flag at bit 5, reset value 0.
// - Flag clears only on software writing 0; writing 1 leaves it alone.
// - Bit 7 of control one picks sleep or standby on sleep; resets 0.
// - Bit 3 of control one picks subclock after watch mode; resets 0.
// - Bit 3 of control two joins the mode choice on sleep; resets 0.
// - Bit 2 of control two picks medium speed on wake; resets 0.
// - Module stop bit 0 holds its peripheral in standby, 1 lets it run.
// - Stop bits: 7 serial B, 6-5 serial A, 4 SAR, 3 DS, 2 TF, 1 flash, 0 clock.
// - Module stop register resets with bits 7, 3 and 1 set.
// - Mask ROM variant: bit 7 of stop register reserved, unreadable, unwritable.
// - Stopping either serial A channel resets that channel's registers.
// - Conversion starts on start bit while converter mode bit is 0 and stop bit 3 is 1.
module smms_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        mask_rom_variant,
    input  wire logic        dsadc_conv_done,
    input  wire logic        conversion_start_bit,
    input  wire logic        converter_mode_bit,
    output logic             dsadc_irq_request,
    output logic             dsadc_conv_start,
    output logic             software_standby_select,
    output logic             low_speed_select,
    output logic             direct_transfer_select,
    output logic             medium_speed_select,
    output logic      [7:0]  module_run,
    output logic             serial_unit_a_ch1_reset,
    output logic             serial_unit_a_ch2_reset,
    output logic             irq
);
    smms_pkg::smms_apb_state_t state_q;
    smms_pkg::smms_byte_t      halt_one_q;
    logic                      irq_en_q;
    logic                      irq_flag_q;
    logic                      software_standby_select_q;
    logic                      low_speed_select_q;
    logic                      direct_transfer_select_q;
    logic                      medium_speed_select_q;
    logic [1:0]                evt_en_q;
    logic [1:0]                evt_status;
    logic                      wr_fire;
    logic                      rd_fire;
    logic                      addr_ok;
    logic [15:0]               off;
    logic [31:0]               rdata_d;
    logic [31:0]               prdata_q;
    logic                      slverr_q;
    logic                      start_q;
    logic                      start_rise;
    logic                      flag_clear;
    logic                      evt_clear_wr;
    logic                      hit_sysctl_one;
    logic                      hit_sysctl_two;
    logic                      hit_irq_en;
    logic                      hit_irq_req;
    logic                      hit_halt_one;
    logic                      hit_evt_status;
    logic                      hit_evt_clear;
    logic                      hit_evt_enable;
    logic                      wr_sysctl_one;
    logic                      wr_sysctl_two;
    logic                      wr_irq_en;
    logic                      wr_irq_req;
    logic                      wr_halt_one;
    logic                      wr_evt_enable;
    smms_pkg::smms_byte_t      img_sysctl_one;
    smms_pkg::smms_byte_t      img_sysctl_two;
    smms_pkg::smms_byte_t      img_irq_en;
    smms_pkg::smms_byte_t      img_irq_req;
    smms_pkg::smms_byte_t      img_halt_one;
    smms_pkg::smms_byte_t      img_evt_status;
    smms_pkg::smms_byte_t      img_evt_enable;

    // Offsets are word indices: some are not multiples of four, so byte address is index * 4
    assign off = paddr[17:2];

    // One hit per register index
    always_comb begin
        hit_sysctl_one = 1'h0;
        hit_sysctl_two = 1'h0;
        hit_irq_en     = 1'h0;
        hit_irq_req    = 1'h0;
        hit_halt_one   = 1'h0;
        hit_evt_status = 1'h0;
        hit_evt_clear  = 1'h0;
        hit_evt_enable = 1'h0;
        case (off)
            `SMMS_OFF_SYSCTL_ONE:   hit_sysctl_one = 1'h1;
            `SMMS_OFF_SYSCTL_TWO:   hit_sysctl_two = 1'h1;
            `SMMS_OFF_IRQ_EN_TWO:   hit_irq_en     = 1'h1;
            `SMMS_OFF_IRQ_REQ_TWO:  hit_irq_req    = 1'h1;
            `SMMS_OFF_CLK_HALT_ONE: hit_halt_one   = 1'h1;
            `SMMS_OFF_EVT_STATUS:   hit_evt_status = 1'h1;
            `SMMS_OFF_EVT_CLEAR:    hit_evt_clear  = 1'h1;
            `SMMS_OFF_EVT_ENABLE:   hit_evt_enable = 1'h1;
            default: begin
                hit_sysctl_one = 1'h0;
            end
        endcase
    end

    // Misaligned or out-of-range addresses fail addr_ok, so they write nothing, read 0 and answer with an error
    assign addr_ok = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0)
                     && (hit_sysctl_one || hit_sysctl_two || hit_irq_en || hit_irq_req
                         || hit_halt_one || hit_evt_status || hit_evt_clear
                         || hit_evt_enable);

    // One wait state: setup, first access cycle stalls, second completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= smms_pkg::SMMS_APB_IDLE;
        end else begin
            case (state_q)
                smms_pkg::SMMS_APB_IDLE: begin
                    if (psel && penable) begin
                        state_q <= smms_pkg::SMMS_APB_ACCESS;
                    end
                end
                smms_pkg::SMMS_APB_ACCESS: begin
                    state_q <= smms_pkg::SMMS_APB_IDLE;
                end
                default: begin
                    state_q <= smms_pkg::SMMS_APB_IDLE;
                end
            endcase
        end
    end

    // Ready lasts one cycle, so every access pays exactly one wait state
    assign pready  = (state_q == smms_pkg::SMMS_APB_ACCESS);
    assign wr_fire = psel && penable && pready && pwrite && addr_ok && pstrb[0];
    assign rd_fire = psel && penable && pready && !pwrite;

    // Per-register write strobes on the completing access edge
    assign wr_sysctl_one = wr_fire && hit_sysctl_one;
    assign wr_sysctl_two = wr_fire && hit_sysctl_two;
    assign wr_irq_en     = wr_fire && hit_irq_en;
    assign wr_irq_req    = wr_fire && hit_irq_req;
    assign wr_halt_one   = wr_fire && hit_halt_one;
    assign wr_evt_enable = wr_fire && hit_evt_enable;

    // Registers are byte wide: only lane 0 carries data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            software_standby_select_q <= `SMMS_RST_SW_STANDBY;
            low_speed_select_q <= `SMMS_RST_LOW_SPEED;
        end else if (wr_sysctl_one) begin
            software_standby_select_q <= pwdata[`SMMS_BIT_SW_STANDBY];
            low_speed_select_q <= pwdata[`SMMS_BIT_LOW_SPEED];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direct_transfer_select_q <= `SMMS_RST_DIRECT_XFER;
            medium_speed_select_q <= `SMMS_RST_MEDIUM_SPEED;
        end else if (wr_sysctl_two) begin
            direct_transfer_select_q <= pwdata[`SMMS_BIT_DIRECT_XFER];
            medium_speed_select_q <= pwdata[`SMMS_BIT_MEDIUM_SPEED];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= `SMMS_RST_DSADC_IRQ_EN;
        end else if (wr_irq_en) begin
            irq_en_q <= pwdata[`SMMS_BIT_DSADC_IRQ];
        end
    end

    // Completion in the same cycle as a clearing write keeps the flag set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_q <= `SMMS_RST_DSADC_IRQ_FLAG;
        end else if (dsadc_conv_done) begin
            irq_flag_q <= 1'h1;
        end else if (flag_clear) begin
            irq_flag_q <= 1'h0;
        end
    end

    assign flag_clear = wr_irq_req && !pwdata[`SMMS_BIT_DSADC_IRQ];

    // Bit 7 ignores writes and keeps its current value when it does not exist on the part
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_one_q <= `SMMS_RST_CLK_HALT_ONE;
        end else if (wr_halt_one) begin
            halt_one_q[6:0] <= pwdata[6:0];
            if (!mask_rom_variant) begin
                halt_one_q[`SMMS_BIT_SERIAL_B] <= pwdata[`SMMS_BIT_SERIAL_B];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_en_q <= `SMMS_RST_EVT_ENABLE;
        end else if (wr_evt_enable) begin
            evt_en_q <= pwdata[1:0];
        end
    end

    // Start requests are edge detected so a held start bit fires once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q <= 1'h0;
        end else begin
            start_q <= conversion_start_bit;
        end
    end

    assign start_rise = conversion_start_bit && !start_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dsadc_conv_start <= 1'h0;
        end else begin
            dsadc_conv_start <= start_rise && !converter_mode_bit
                                && halt_one_q[3];
        end
    end

    // Event bits: 0 converter completion, 1 conversion start accepted
    assign evt_clear_wr = wr_fire && hit_evt_clear;

    smms_sticky_bit u_evt_done (
        .pclk        (pclk),
        .presetn     (presetn),
        .set_pulse   (dsadc_conv_done),
        .clear_pulse (evt_clear_wr && pwdata[0]),
        .flag_q      (evt_status[0])
    );

    smms_sticky_bit u_evt_start (
        .pclk        (pclk),
        .presetn     (presetn),
        .set_pulse   (dsadc_conv_start),
        .clear_pulse (evt_clear_wr && pwdata[1]),
        .flag_q      (evt_status[1])
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'h0;
        end else begin
            irq <= |(evt_status & evt_en_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dsadc_irq_request <= 1'h0;
        end else begin
            dsadc_irq_request <= irq_flag_q && irq_en_q;
        end
    end

    assign software_standby_select = software_standby_select_q;
    assign low_speed_select        = low_speed_select_q;
    assign direct_transfer_select  = direct_transfer_select_q;
    assign medium_speed_select     = medium_speed_select_q;
    assign module_run              = halt_one_q;

    // Serial A channel held in reset for as long as its stop bit is 0
    assign serial_unit_a_ch1_reset = !halt_one_q[`SMMS_BIT_SERIAL_A_CH1];
    assign serial_unit_a_ch2_reset = !halt_one_q[`SMMS_BIT_SERIAL_A_CH2];

    // Images of each register as software reads it; unused bits read 0
    always_comb begin
        img_sysctl_one                         = 8'h00;
        img_sysctl_one[`SMMS_BIT_SW_STANDBY]   = software_standby_select_q;
        img_sysctl_one[`SMMS_BIT_LOW_SPEED]    = low_speed_select_q;
        img_sysctl_two                         = 8'h00;
        img_sysctl_two[`SMMS_BIT_DIRECT_XFER]  = direct_transfer_select_q;
        img_sysctl_two[`SMMS_BIT_MEDIUM_SPEED] = medium_speed_select_q;
        img_irq_en                             = 8'h00;
        img_irq_en[`SMMS_BIT_DSADC_IRQ]        = irq_en_q;
        img_irq_req                            = 8'h00;
        img_irq_req[`SMMS_BIT_DSADC_IRQ]       = irq_flag_q;
        img_halt_one                           = halt_one_q;
        if (mask_rom_variant) begin
            img_halt_one[`SMMS_BIT_SERIAL_B]   = 1'h0;
        end
        img_evt_status                         = {6'h00, evt_status};
        img_evt_enable                         = {6'h00, evt_en_q};
    end

    // The clear register is write-only and reads as zero, but unlike a hole it answers without an error
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_sysctl_one) begin
            rdata_d[7:0] = img_sysctl_one;
        end
        if (hit_sysctl_two) begin
            rdata_d[7:0] = img_sysctl_two;
        end
        if (hit_irq_en) begin
            rdata_d[7:0] = img_irq_en;
        end
        if (hit_irq_req) begin
            rdata_d[7:0] = img_irq_req;
        end
        if (hit_halt_one) begin
            rdata_d[7:0] = img_halt_one;
        end
        if (hit_evt_status) begin
            rdata_d[7:0] = img_evt_status;
        end
        if (hit_evt_enable) begin
            rdata_d[7:0] = img_evt_enable;
        end
        if (!addr_ok) begin
            rdata_d = 32'h0000_0000;
        end
    end

    // Read data and error are registered during the wait cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'h0;
        end else if (psel && penable && !pready) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            slverr_q <= !addr_ok;
        end
    end

    assign prdata  = rd_fire ? prdata_q : 32'h0000_0000;
    assign pslverr = pready && slverr_q;
endmodule : smms_regs

// *** logic/smms_sticky_bit.sv ***
// One sticky event bit whose set wins over a clear in the same cycle
module smms_sticky_bit (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    output logic      flag_q
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'h0;
        end else if (set_pulse) begin
            flag_q <= 1'h1;
        end else if (clear_pulse) begin
            flag_q <= 1'h0;
        end
    end
endmodule : smms_sticky_bit
